// File: core/nmt_consts.svh
// Constants for the non-maskable trap and interrupt hold block
`ifndef NMT_CONSTS_SVH
`define NMT_CONSTS_SVH

// Register addresses on the plain register port
`define NMT_ADDR_ICF       4'h0
`define NMT_ADDR_ICS       4'h1
`define NMT_ADDR_RCR       4'h2
`define NMT_ADDR_OSC       4'h3
`define NMT_ADDR_SLIM      4'h4
`define NMT_ADDR_HOLD      4'h5
`define NMT_ADDR_CPU       4'h6

// Field positions
`define NMT_BIT_OSC_FAILURE_FLAG    1
`define NMT_BIT_STACK_ERROR_FLAG     2
`define NMT_BIT_ADDRESS_ERROR_FLAG    3
`define NMT_BIT_MATH_ERROR_FLAG    4
`define NMT_BIT_DIV0       6
`define NMT_BIT_HOLDACT    14
`define NMT_BIT_TRAPRST    15
`define NMT_BIT_CLKFAIL    3
`define NMT_BIT_PRIO3      3

// Fixed trap levels
`define NMT_LVL_MATH       4'hb
`define NMT_LVL_STACK      4'hc
`define NMT_LVL_ADDR       4'hd
`define NMT_LVL_OSC        4'he

// Stack floor after reset and top of data space
`define NMT_SP_RESET       16'h0800
`define NMT_DATA_TOP       17'h0ffff

// Soft trap sample and acknowledge delay, in cycles
`define NMT_SOFT_DELAY     2
// Longest hold the disable instruction can request
`define NMT_HOLD_MAX       16384

`endif

// File: core/nmt_pkg.sv
// Types for the non-maskable trap and interrupt hold block
package nmt_pkg;

  typedef enum logic [1:0] {
    NMT_IDLE,
    NMT_SERVING
  } nmt_state_e;

  // One stack-pointer based effective address per cycle
  typedef struct packed {
    logic        valid;
    logic [16:0] addr;
  } nmt_ea_s;

  // Address error causes from the pipeline
  typedef struct packed {
    logic odd_word;
    logic odd_bit_ind;
    logic unimpl_data;
    logic unimpl_branch;
    logic unimpl_pc;
  } nmt_aerr_s;

  // Oscillator failure causes
  typedef struct packed {
    logic mon_enable;
    logic clk_lost;
    logic pll_unlock;
    logic pll_nolock_por;
  } nmt_osc_s;

  // Register port request
  typedef struct packed {
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } nmt_reg_req_s;

  // Exception request to the core
  typedef struct packed {
    logic       req;
    logic [3:0] level;
  } nmt_exc_s;

  typedef struct packed {
    nmt_state_e  state;
    logic [3:0]  serving;
    logic [3:0]  pend;
    logic [1:0]  soft_dly;
    logic        oscf;
    logic        stkf;
    logic        addrf;
    logic        mathf;
    logic        div0f;
    logic        trap_rst;
    logic        clk_fail;
    logic        prio3;
    logic [15:0] slim;
    logic        slim_ok;
    logic [14:0] hold;
    logic        hold_act;
    logic        halt;
    logic        wr_block;
    logic        rst_req;
    logic [15:0] rdata;
    nmt_exc_s    exc;
  } nmt_st_s;

endpackage

// File: core/nmt_trap_unit.sv
// Non-maskable trap priority, status flags, stack checks and interrupt hold
//
// Operation
// - Math trap level 11, stack 12, soft.
// - Soft traps acknowledged two cycles after sampling.
// - Address trap level 13, oscillator 14, hard.
// - Hard trap halts code until acknowledged, processed.
// - Stack below 0x0800 raises stack trap.
// - Limit check off until limit written.
// - Stack address over limit or wrap traps.
// - Stack error flag at bit 2.
// - Divide by zero sets bit 6, math trap.
// - Math flag bit 4, held while cause.
// - Higher trap preempts; lower stays pending.
// - Lower hard trap during higher resets, flag 15.
// - Oscillator trap from three clock events.
// - Oscillator flag bit 1 plus clock fail.
// - Address trap from five address cases.
// - Address trap blocks writes, flag bit 3.
// - Hold blocks priority 1-6 up to 16384.
// - Hold counter decrements each cycle to zero.
// - Hold counter readable, writable, clear ends hold.
// - Writing counter at zero starts no hold.
// - Hold active status at bit 14.
// - Trap starts only above current priority.
// - Priority bit 3 set by trap, software clears.
//
// The address-and-strobe port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "nmt_consts.svh"

module nmt_trap_unit #(
  parameter int HOLD_W = 15
) (
  // Clock, reset, enable
  input  wire logic                 clk_in,
  input  wire logic                 rst_in,
  input  wire logic                 ce_in,
  // Register port
  input  wire nmt_pkg::nmt_reg_req_s reg_in,
  output logic [15:0]               rdata_out,
  // Pipeline events
  input  wire nmt_pkg::nmt_ea_s     stack_ea_in,
  input  wire logic [15:0]          stack_pointer_working_reg_in,
  input  wire logic                 div_first_iter_in,
  input  wire logic                 divisor_zero_in,
  input  wire nmt_pkg::nmt_aerr_s   aerr_in,
  input  wire nmt_pkg::nmt_osc_s    osc_in,
  input  wire logic                 disable_interrupts_instr_exec_in,
  input  wire logic [13:0]          disable_interrupts_instr_count_in,
  input  wire logic [3:0]           cpu_ipl_in,
  input  wire logic                 trap_done_in,
  // Core side results
  output nmt_pkg::nmt_exc_s         exc_out,
  output logic                      halt_out,
  output logic                      data_wr_block_out,
  output logic                      irq_1to6_block_out,
  output logic                      trap_reset_req_out
);
  import nmt_pkg::*;

  // The state struct carries a fixed 15-bit hold field
  if (HOLD_W != 15) begin : g_hold_w_check
    $error("HOLD_W must be 15 to match the hold counter field");
  end

  nmt_st_s r, n;

  logic       osc_ev, addr_ev, stk_ev, math_ev;
  logic [3:0] raw;
  logic [3:0] want;
  logic [3:0] top_lvl;
  logic [3:0] cur_lvl;

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    n = r;
    osc_ev = (osc_in.mon_enable & osc_in.clk_lost) | osc_in.pll_unlock |
             (osc_in.mon_enable & osc_in.pll_nolock_por);
    addr_ev = |aerr_in;
    stk_ev = (stack_pointer_working_reg_in < `NMT_SP_RESET) |
             (stack_ea_in.valid & (stack_ea_in.addr > `NMT_DATA_TOP)) |
             (stack_ea_in.valid & r.slim_ok &
              (stack_ea_in.addr[15:0] > r.slim));
    math_ev = div_first_iter_in & divisor_zero_in;
    raw = {osc_ev, addr_ev, stk_ev, math_ev};

    // Register writes first, so hardware sets below win over clears
    if (reg_in.wr) begin
      unique case (reg_in.addr)
        `NMT_ADDR_ICF: begin
          n.oscf  = r.oscf  & reg_in.wdata[`NMT_BIT_OSC_FAILURE_FLAG];
          n.stkf  = r.stkf  & reg_in.wdata[`NMT_BIT_STACK_ERROR_FLAG];
          n.addrf = r.addrf & reg_in.wdata[`NMT_BIT_ADDRESS_ERROR_FLAG];
          n.div0f = r.div0f & reg_in.wdata[`NMT_BIT_DIV0];
          // math flag held while a cause remains
          n.mathf = r.mathf & (reg_in.wdata[`NMT_BIT_MATH_ERROR_FLAG] | r.div0f |
                               math_ev);
        end
        `NMT_ADDR_RCR: n.trap_rst = r.trap_rst & reg_in.wdata[`NMT_BIT_TRAPRST];
        `NMT_ADDR_OSC: n.clk_fail = r.clk_fail & reg_in.wdata[`NMT_BIT_CLKFAIL];
        // first write arms the limit check
        `NMT_ADDR_SLIM: begin
          n.slim    = reg_in.wdata;
          n.slim_ok = 1'b1;
        end
        // a write at zero starts nothing
        `NMT_ADDR_HOLD: begin
          if (r.hold != '0) n.hold = reg_in.wdata[HOLD_W-1:0];
        end
        `NMT_ADDR_CPU: n.prio3 = r.prio3 & reg_in.wdata[`NMT_BIT_PRIO3];
        default: ;
      endcase
    end

    if (osc_ev) begin
      n.oscf     = 1'b1;
      n.clk_fail = 1'b1;
    end
    if (stk_ev) n.stkf = 1'b1;
    if (addr_ev) n.addrf = 1'b1;
    n.wr_block = addr_ev;
    if (math_ev) begin
      n.div0f = 1'b1;
      n.mathf = 1'b1;
    end

    n.pend = r.pend | raw;

    // address trap meets an oscillator trap raised, pending or served, or an address trap in service
    n.rst_req = 1'b0;
    if ((addr_ev & (r.pend[3] | r.serving[3] | osc_ev)) |
        (addr_ev & r.serving[2])) begin
      n.rst_req  = 1'b1;
      n.trap_rst = 1'b1;
    end

    want = r.pend;
    if (want[3])      top_lvl = `NMT_LVL_OSC;
    else if (want[2]) top_lvl = `NMT_LVL_ADDR;
    else if (want[1]) top_lvl = `NMT_LVL_STACK;
    else if (want[0]) top_lvl = `NMT_LVL_MATH;
    else              top_lvl = 4'h0;

    cur_lvl = r.serving[3] ? `NMT_LVL_OSC : r.serving[2] ? `NMT_LVL_ADDR :
              r.serving[1] ? `NMT_LVL_STACK : r.serving[0] ? `NMT_LVL_MATH :
              cpu_ipl_in;

    // halt while a hard trap is pending
    n.halt = n.pend[3] | n.pend[2];

    n.exc.req = 1'b0;
    if (top_lvl != 4'h0 && top_lvl <= `NMT_LVL_STACK &&
        r.soft_dly != 2'(`NMT_SOFT_DELAY)) begin
      n.soft_dly = r.soft_dly + 2'h1;
    end
    else if (top_lvl > cur_lvl) begin
      n.exc.req   = 1'b1;
      n.exc.level = top_lvl;
      n.soft_dly  = 2'h0;
      n.state     = NMT_SERVING;
      n.prio3     = 1'b1;
      unique case (top_lvl)
        `NMT_LVL_OSC: begin
          n.pend[3]    = raw[3];
          n.serving[3] = 1'b1;
        end
        `NMT_LVL_ADDR: begin
          n.pend[2]    = raw[2];
          n.serving[2] = 1'b1;
        end
        `NMT_LVL_STACK: begin
          n.pend[1]    = raw[1];
          n.serving[1] = 1'b1;
        end
        default: begin
          n.pend[0]    = raw[0];
          n.serving[0] = 1'b1;
        end
      endcase
    end

    // Done retires the highest trap in service; the lower resumes
    if (trap_done_in && r.state == NMT_SERVING) begin
      if (r.serving[3])      n.serving[3] = 1'b0;
      else if (r.serving[2]) n.serving[2] = 1'b0;
      else if (r.serving[1]) n.serving[1] = 1'b0;
      else                   n.serving[0] = 1'b0;
      if (n.serving == 4'h0) n.state = NMT_IDLE;
    end
    n.halt = n.halt | n.serving[3] | n.serving[2];

    // counts every cycle down to zero
    if (disable_interrupts_instr_exec_in) begin
      n.hold = HOLD_W'(disable_interrupts_instr_count_in) + HOLD_W'(1);
    end else if (!(reg_in.wr && reg_in.addr == `NMT_ADDR_HOLD) && r.hold != '0) begin
      n.hold = r.hold - HOLD_W'(1);
    end
    n.hold_act = (n.hold != '0);

    n.rdata = 16'h0000;
    if (reg_in.rd) begin
      unique case (reg_in.addr)
        `NMT_ADDR_ICF: begin
          n.rdata[`NMT_BIT_OSC_FAILURE_FLAG] = r.oscf;
          n.rdata[`NMT_BIT_STACK_ERROR_FLAG]  = r.stkf;
          n.rdata[`NMT_BIT_ADDRESS_ERROR_FLAG] = r.addrf;
          n.rdata[`NMT_BIT_MATH_ERROR_FLAG] = r.mathf;
          n.rdata[`NMT_BIT_DIV0]    = r.div0f;
        end
        `NMT_ADDR_ICS: n.rdata[`NMT_BIT_HOLDACT] = r.hold_act;
        `NMT_ADDR_RCR: n.rdata[`NMT_BIT_TRAPRST] = r.trap_rst;
        `NMT_ADDR_OSC: n.rdata[`NMT_BIT_CLKFAIL] = r.clk_fail;
        `NMT_ADDR_SLIM: n.rdata = r.slim;
        `NMT_ADDR_HOLD: n.rdata = 16'(r.hold);
        `NMT_ADDR_CPU: n.rdata[`NMT_BIT_PRIO3] = r.prio3;
        default: n.rdata = 16'h0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      r <= '0;
    end else if (ce_in) begin
      r <= n;
    end
  end

  assign rdata_out          = r.rdata;
  assign exc_out            = r.exc;
  assign halt_out           = r.halt;
  assign data_wr_block_out  = r.wr_block;
  // priority 1 to 6 blocked while counting
  assign irq_1to6_block_out = r.hold_act;
  assign trap_reset_req_out = r.rst_req;

endmodule

// File: verification/nmt_trap_sva.sv
// Port assertions for the trap unit
`timescale 1ns/1ps
module nmt_trap_sva (
  // Clock and reset
  input wire logic              clk_in,
  input wire logic              rst_in,
  // Watched inputs
  input wire nmt_pkg::nmt_aerr_s aerr_in,
  input wire logic              div_first_iter_in,
  input wire logic              divisor_zero_in,
  input wire logic              disable_interrupts_instr_exec_in,
  input wire logic [13:0]       disable_interrupts_instr_count_in,
  input wire logic [3:0]        cpu_ipl_in,
  input wire logic              trap_done_in,
  // Watched outputs
  input wire nmt_pkg::nmt_exc_s exc_out,
  input wire logic              halt_out,
  input wire logic              data_wr_block_out,
  input wire logic              irq_1to6_block_out,
  input wire logic              trap_reset_req_out
);
  import nmt_pkg::*;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  a_wr_block: assert property (|aerr_in |=> data_wr_block_out)
    else $error("write block missing");
  a_hard_trap: assert property (|aerr_in && !halt_out && !data_wr_block_out
    && !exc_out.req && cpu_ipl_in == 4'h0 |-> ##2 halt_out && exc_out.level == 4'hd)
    else $error("address trap late");
  a_halt_hold: assert property (halt_out && !trap_done_in && !trap_reset_req_out
    && !$past(trap_reset_req_out) |=> halt_out) else $error("halt dropped");
  a_exc_prio: assert property (exc_out.req |-> exc_out.level > cpu_ipl_in)
    else $error("request below priority");
  a_exc_levels: assert property (exc_out.req
    |-> exc_out.level inside {4'hb, 4'hc, 4'hd, 4'he}) else $error("bad trap level");
  a_reset_pulse: assert property (trap_reset_req_out |=> !trap_reset_req_out)
    else $error("reset request too long");
  a_hold_start: assert property (disable_interrupts_instr_exec_in && disable_interrupts_instr_count_in != 14'h0
    |=> irq_1to6_block_out) else $error("hold not started");
  a_hold_cause: assert property ($rose(irq_1to6_block_out) |-> $past(disable_interrupts_instr_exec_in))
    else $error("hold without instruction");
  a_soft_delay: assert property (div_first_iter_in && divisor_zero_in && !halt_out
    && !exc_out.req && cpu_ipl_in == 4'h0 |-> ##1 !exc_out.req [*3] ##1
    exc_out.req && exc_out.level >= 4'hb) else $error("soft trap timing");
  c_reset: cover property (trap_reset_req_out);
  c_osc: cover property (exc_out.req && exc_out.level == 4'he);
  c_hold_end: cover property ($fell(irq_1to6_block_out));
endmodule
bind nmt_trap_unit nmt_trap_sva u_nmt_trap_sva (.clk_in, .rst_in, .aerr_in,
  .div_first_iter_in, .divisor_zero_in, .disable_interrupts_instr_exec_in, .disable_interrupts_instr_count_in, .cpu_ipl_in,
  .trap_done_in, .exc_out, .halt_out, .data_wr_block_out, .irq_1to6_block_out,
  .trap_reset_req_out);

// File: verification/nmt_core_model.sv
// Core pipeline model that serves trap requests
`timescale 1ns/1ps
module nmt_core_model #(
  parameter int DLY = 12
) (
  input  wire logic              clk_in,
  input  wire logic              rst_in,
  input  wire nmt_pkg::nmt_exc_s exc_in,
  output logic                   done_out = 1'b0
);
  import nmt_pkg::*;
  int cnt   = 0;
  int depth = 0;
  // newest is highest; a preempted trap restarts its service time
  always @(posedge clk_in) begin
    done_out <= 1'b0;
    if (rst_in) begin
      cnt   <= 0;
      depth <= 0;
    end else if (exc_in.req) begin
      cnt   <= DLY;
      depth <= depth + 1;
    end else if (cnt == 1) begin
      cnt      <= (depth > 1) ? DLY : 0;
      depth    <= depth - 1;
      done_out <= 1'b1;
    end else if (cnt > 1)
      cnt <= cnt - 1;
  end
endmodule

// File: verification/tb_nmt_trap_unit.sv
// Self-checking bench for the trap unit
`timescale 1ns/1ps
`include "nmt_consts.svh"
module tb_nmt_trap_unit;
  import nmt_pkg::*;
  logic         clk_in = 1'b0, rst_in = 1'b1, ce = 1'b1, disable_interrupts_instr = 1'b0, dfi = 1'b0, dz = 1'b0;
  logic [3:0]   ipl    = 4'h0;
  logic [13:0]  dcnt   = 14'h0;
  logic [15:0]  sp     = `NMT_SP_RESET;
  nmt_reg_req_s rq     = '0;
  nmt_ea_s      ea     = '0;
  nmt_aerr_s    ae     = '0;
  nmt_osc_s     os     = '0;
  logic [15:0]  rdata, rd_v;
  nmt_exc_s     exc;
  logic         halt, wblk, iblk, trst, done;
  logic [3:0]   lv_log [64];
  int           n_fail = 0, checks_done = 0, n_lv = 0, n_rst = 0;
  always #2 clk_in = ~clk_in;
  nmt_trap_unit u_nmt_trap_unit (.clk_in, .rst_in, .ce_in(ce), .reg_in(rq),
    .rdata_out(rdata), .stack_ea_in(ea), .stack_pointer_working_reg_in(sp),
    .div_first_iter_in(dfi), .divisor_zero_in(dz), .aerr_in(ae), .osc_in(os),
    .disable_interrupts_instr_exec_in(disable_interrupts_instr), .disable_interrupts_instr_count_in(dcnt), .cpu_ipl_in(ipl), .trap_done_in(done),
    .exc_out(exc), .halt_out(halt), .data_wr_block_out(wblk),
    .irq_1to6_block_out(iblk), .trap_reset_req_out(trst));
  nmt_core_model u_nmt_core_model (.clk_in, .rst_in, .exc_in(exc), .done_out(done));
  always @(posedge clk_in) begin
    if (exc.req === 1'b1) begin
      lv_log[n_lv] <= exc.level;
      n_lv <= n_lv + 1;
    end
    if (trst === 1'b1)
      n_rst <= n_rst + 1;
  end
  ////////////////////////////////////////
  task automatic chk(input logic [15:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %0t got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic do_reset;
    @(posedge clk_in);
    rst_in <= 1'b1;
    repeat (6) @(posedge clk_in);
    rst_in <= 1'b0;
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_in);
    rq <= '{a, d, 1'b1, 1'b0};
    @(posedge clk_in);
    rq.wr <= 1'b0;
  endtask
  task automatic rdc(input logic [3:0] a, input logic [15:0] m, e);
    @(posedge clk_in);
    rq <= '{a, 16'h0, 1'b0, 1'b1};
    @(posedge clk_in);
    rq.rd <= 1'b0;
    #1 rd_v = rdata;
    chk(rd_v & m, e);
  endtask
  // Flags are sticky, so each served trap is cleared before the next
  task automatic serve;
    for (int k = 0; k < 40 && done !== 1'b1; k++)
      @(posedge clk_in) #1;
    wr(`NMT_ADDR_ICF, 16'h0);
    wr(`NMT_ADDR_OSC, 16'h0);
    wr(`NMT_ADDR_CPU, 16'h0);
  endtask
  task automatic flag(input logic [15:0] m, e);
    cyc(5);
    rdc(`NMT_ADDR_ICF, m, e);
    serve();
  endtask
  task automatic ev_ea(input logic [16:0] a);
    @(posedge clk_in);
    ea <= '{1'b1, a};
    @(posedge clk_in);
    ea.valid <= 1'b0;
  endtask
  ////////////////////////////////////////
  task automatic t_addr;
    for (int i = 0; i < 5; i++) begin
      @(posedge clk_in);
      ae <= nmt_aerr_s'(5'h1 << i);
      @(posedge clk_in);
      ae <= '0;
      #1 chk({15'h0, wblk}, 16'h1);
      cyc(2);
      chk({15'h0, halt}, 16'h1);
      rdc(`NMT_ADDR_ICF, 16'h005e, 16'h0008);
      rdc(`NMT_ADDR_CPU, 16'h0008, 16'h0008);
      serve();
      wr(`NMT_ADDR_CPU, 16'h0008);
      rdc(`NMT_ADDR_CPU, 16'h0008, 16'h0);
      rdc(`NMT_ADDR_ICF, 16'h005e, 16'h0);
    end
  endtask
  task automatic t_osc;
    logic [3:0] c [4] = '{4'b1100, 4'b0010, 4'b1001, 4'b1100};
    int b;
    for (int i = 0; i < 4; i++) begin
      b = n_lv;
      @(posedge clk_in);
      os <= nmt_osc_s'(c[i]);
      ipl <= (i == 3) ? 4'he : 4'h0;
      @(posedge clk_in);
      os <= '0;
      cyc(4);
      chk(16'(n_lv - b), (i == 3) ? 16'h0 : 16'h1);
      if (i != 3) chk({12'h0, lv_log[n_lv - 1]}, 16'h000e);
      rdc(`NMT_ADDR_ICF, 16'h005e, 16'h0002);
      rdc(`NMT_ADDR_OSC, 16'h0008, 16'h0008);
      @(posedge clk_in);
      ipl <= 4'h0;
      serve();
    end
  endtask
  task automatic t_stack;
    ev_ea(17'h09000);
    flag(16'h0004, 16'h0);
    wr(`NMT_ADDR_SLIM, 16'h8000);
    ev_ea(17'h08000);
    flag(16'h0004, 16'h0);
    ev_ea(17'h08002);
    flag(16'h0004, 16'h0004);
    ev_ea(17'h10002);
    flag(16'h0004, 16'h0004);
    @(posedge clk_in);
    sp <= 16'h07fe;
    @(posedge clk_in);
    sp <= `NMT_SP_RESET;
    flag(16'h0004, 16'h0004);
  endtask
  task automatic t_math;
    int b;
    @(posedge clk_in);
    dz <= 1'b1;
    @(posedge clk_in);
    dz <= 1'b0;
    flag(16'h0050, 16'h0);
    b = n_lv;
    @(posedge clk_in);
    {dfi, dz} <= 2'b11;
    sp <= 16'h07fe;
    @(posedge clk_in);
    {dfi, dz} <= 2'b00;
    sp <= `NMT_SP_RESET;
    cyc(5);
    rdc(`NMT_ADDR_ICF, 16'h0054, 16'h0054);
    wr(`NMT_ADDR_ICF, 16'h0040);
    rdc(`NMT_ADDR_ICF, 16'h0050, 16'h0050);
    serve();
    serve();
    chk({12'h0, lv_log[b]}, 16'h000c);
    chk({12'h0, lv_log[b + 1]}, 16'h000b);
  endtask
  // Address trap preempts a math trap in service; both retire in turn
  task automatic t_nest;
    int b;
    b = n_lv;
    @(posedge clk_in);
    {dfi, dz} <= 2'b11;
    @(posedge clk_in);
    {dfi, dz} <= 2'b00;
    cyc(6);
    @(posedge clk_in);
    ae <= nmt_aerr_s'(5'h1);
    @(posedge clk_in);
    ae <= '0;
    cyc(3);
    chk({12'h0, lv_log[b]}, 16'h000b);
    chk({12'h0, lv_log[b + 1]}, 16'h000d);
    serve();
    chk({15'h0, halt}, 16'h0);
    serve();
    chk(16'(n_lv - b), 16'h2);
  endtask
  task automatic t_hold;
    int k;
    @(posedge clk_in);
    disable_interrupts_instr <= 1'b1;
    dcnt <= 14'd5;
    @(posedge clk_in);
    disable_interrupts_instr <= 1'b0;
    #1;
    for (k = 0; k < 99 && iblk === 1'b1; k++)
      @(posedge clk_in) #1;
    // The count is loaded plus one, so a count of 5 blocks for 6 cycles
    chk(16'(k), 16'd6);
    wr(`NMT_ADDR_HOLD, 16'h0010);
    #1 chk({15'h0, iblk}, 16'h0);
    @(posedge clk_in);
    disable_interrupts_instr <= 1'b1;
    @(posedge clk_in);
    disable_interrupts_instr <= 1'b0;
    wr(`NMT_ADDR_HOLD, 16'd50);
    cyc(10);
    chk({15'h0, iblk}, 16'h1);
    rdc(`NMT_ADDR_ICS, 16'h4000, 16'h4000);
    rdc(`NMT_ADDR_HOLD, 16'hffff, 16'd37);
    wr(`NMT_ADDR_HOLD, 16'h0);
    #1 chk({15'h0, iblk}, 16'h0);
  endtask
  // A low enable freezes the hold count
  task automatic t_freeze;
    @(posedge clk_in);
    disable_interrupts_instr <= 1'b1;
    dcnt <= 14'd1;
    @(posedge clk_in);
    disable_interrupts_instr <= 1'b0;
    ce   <= 1'b0;
    cyc(8);
    chk({15'h0, iblk}, 16'h1);
    @(posedge clk_in);
    ce <= 1'b1;
    cyc(2);
    chk({15'h0, iblk}, 16'h0);
  endtask
  // An address trap behind a served oscillator trap cannot be taken
  task automatic t_conflict;
    @(posedge clk_in);
    os <= nmt_osc_s'(4'b0010);
    @(posedge clk_in);
    os <= '0;
    repeat (2) @(posedge clk_in);
    ae <= nmt_aerr_s'(5'h1);
    @(posedge clk_in);
    ae <= '0;
    cyc(5);
    chk(16'(n_rst), 16'h1);
    rdc(`NMT_ADDR_RCR, 16'h8000, 16'h8000);
    do_reset();
  endtask
  ////////////////////////////////////////
  task automatic give_verdict;
    if (n_fail == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    do_reset();
    rdc(4'hf, 16'hffff, 16'h0);
    rdc(`NMT_ADDR_HOLD, 16'hffff, 16'h0);
    t_addr();
    t_osc();
    t_stack();
    t_math();
    t_nest();
    t_hold();
    t_freeze();
    t_conflict();
    give_verdict();
  end
  initial begin
    #100000;
    n_fail++;
    give_verdict();
  end
endmodule
